/* hw/updown_pkg.sv */
// package: widths, reset values and carrier types for the 3-bit up/down counter
// assumes: included before the counter module in compile order
package updown_pkg;
  localparam int COUNT_W = 3;
  localparam int CTRL_W = 3;
  localparam int STAT_W = 3;
  localparam int LUT_IN_W = 4;
  localparam logic [COUNT_W-1:0] COUNT_RST = 3'h0;
  localparam logic [COUNT_W-1:0] COUNT_MAX = 3'h7;
  localparam logic [COUNT_W-1:0] COUNT_STEP = 3'h1;
  localparam int DIR_BIT = 0;
  localparam logic DIR_UP = 1'b0;
  localparam logic DIR_DOWN = 1'b1;

  // processor-written control outputs
  typedef struct packed {
    logic spare_two;
    logic spare_one;
    logic direction_select;
  } ctrl_s;

  // processor-read status inputs
  typedef struct packed {
    logic [COUNT_W-1:0] count;
  } stat_s;
endpackage : updown_pkg

/* hw/lut_up_down_counter_3bit.sv */
// counter: 3-bit up/down count from a registered four-input lookup function
// assumes: control word from a processor control register on ref_clk, status
// word read by the processor; control logic on the same clock, no synchroniser
`timescale 1ns/1ps
`default_nettype none

module lut_up_down_counter_3bit (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire updown_pkg::ctrl_s ctrl_word,
  output var updown_pkg::stat_s stat_word,
  output logic [updown_pkg::COUNT_W-1:0] count_out
);
  import updown_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // lookup function

  logic [COUNT_W-1:0] count_ff;
  logic [COUNT_W-1:0] nxt_count;
  logic feedback_bit_zero;
  logic feedback_bit_one;
  logic feedback_bit_two;
  logic direction_select;
  logic [LUT_IN_W-1:0] lut_addr;

  assign feedback_bit_zero = count_ff[0];
  assign feedback_bit_one = count_ff[1];
  assign feedback_bit_two = count_ff[2];
  assign direction_select = ctrl_word.direction_select;
  assign lut_addr = {direction_select, feedback_bit_two, feedback_bit_one,
                     feedback_bit_zero};

  // sixteen-entry table: low half counts up, high half counts down
  always_comb begin
    unique case (lut_addr)
      4'h0: nxt_count = 3'h1;
      4'h1: nxt_count = 3'h2;
      4'h2: nxt_count = 3'h3;
      4'h3: nxt_count = 3'h4;
      4'h4: nxt_count = 3'h5;
      4'h5: nxt_count = 3'h6;
      4'h6: nxt_count = 3'h7;
      4'h7: nxt_count = 3'h0;
      4'h8: nxt_count = 3'h7;
      4'h9: nxt_count = 3'h0;
      4'hA: nxt_count = 3'h1;
      4'hB: nxt_count = 3'h2;
      4'hC: nxt_count = 3'h3;
      4'hD: nxt_count = 3'h4;
      4'hE: nxt_count = 3'h5;
      4'hF: nxt_count = 3'h6;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // output registers

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      count_ff <= COUNT_RST;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign count_out = count_ff;
  assign stat_word.count = count_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_count_up_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_UP) |=> count_ff == $past(count_ff) + COUNT_STEP)
    else $error("count did not step up by one");

  a_count_down_step: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_DOWN) |=> count_ff == $past(count_ff) - COUNT_STEP)
    else $error("count did not step down by one");

  a_wrap_up_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count_ff == COUNT_MAX && ctrl_word.direction_select == DIR_UP) |=> count_ff == COUNT_RST)
    else $error("count did not wrap from 7 to 0");

  a_wrap_down_max: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (count_ff == COUNT_RST && ctrl_word.direction_select == DIR_DOWN) |=> count_ff == COUNT_MAX)
    else $error("count did not wrap from 0 to 7");

  a_status_mirror: assert property (@(posedge ref_clk) disable iff (!rst_n)
    stat_word.count == count_out)
    else $error("status word differs from count");

  a_reset_clears: assert property (@(posedge ref_clk)
    !rst_n |=> count_ff == COUNT_RST)
    else $error("count not cleared by reset");

  // spare bits toggle under the count; only direction may steer it
  a_spares_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($changed(ctrl_word.spare_one) && ctrl_word.direction_select == DIR_UP)
    |=> count_ff == $past(count_ff) + COUNT_STEP)
    else $error("spare control bit disturbed count");

  a_spare_two_ignored: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ($changed(ctrl_word.spare_two) && ctrl_word.direction_select == DIR_DOWN)
    |=> count_ff == $past(count_ff) - COUNT_STEP)
    else $error("second spare bit disturbed count");

  ////////////////////////////////////////////////////////////////////////////
  // lookup wiring checks

  a_lut_feedback_bits: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lut_addr[2:0] == count_ff)
    else $error("lookup feedback inputs not in count bit order");

  a_lut_dir_input: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    lut_addr[3] == ctrl_word.direction_select)
    else $error("lookup input three is not the direction select");

  a_next_up_value: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (lut_addr[3] == DIR_UP)
    |-> nxt_count == count_ff + COUNT_STEP)
    else $error("lookup entry does not count up");

  a_next_down_value: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (lut_addr[3] == DIR_DOWN)
    |-> nxt_count == count_ff - COUNT_STEP)
    else $error("lookup entry does not count down");

  a_status_from_reg: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    stat_word.count == count_ff)
    else $error("status word not taken from the count register");

  ////////////////////////////////////////////////////////////////////////////
  // sequence checks

  // eight steps in one direction bring the count back to where it was
  a_up_eight_cycle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_UP) [*8]
    |=> count_ff == $past(count_ff, 8))
    else $error("eight up steps did not wrap round");

  a_down_eight_cycle: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_DOWN) [*8]
    |=> count_ff == $past(count_ff, 8))
    else $error("eight down steps did not wrap round");

  a_down_twice: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_DOWN) [*2]
    |=> count_ff == $past(count_ff, 2) - 3'h2)
    else $error("two down steps did not subtract two");

  // one step each way leaves the count where it started
  a_flip_up_down: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_UP) ##1 (ctrl_word.direction_select == DIR_DOWN)
    |=> count_ff == $past(count_ff, 2))
    else $error("up then down did not return");

  a_flip_down_up: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_DOWN) ##1 (ctrl_word.direction_select == DIR_UP)
    |=> count_ff == $past(count_ff, 2))
    else $error("down then up did not return");

  a_never_stalls: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    rst_n ##1 rst_n
    |-> count_ff != $past(count_ff))
    else $error("count held across an edge");

  // first edge out of reset steps from the reset value
  a_first_step_up: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    ($rose(rst_n) && ctrl_word.direction_select == DIR_UP)
    |=> count_ff == COUNT_STEP)
    else $error("first step after reset was not to one");

  a_up_twice: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl_word.direction_select == DIR_UP) [*2] |=> count_ff == $past(count_ff, 2) + 3'h2)
    else $error("two up steps did not add two");
endmodule : lut_up_down_counter_3bit

`default_nettype wire

/* verification/fw_model.sv */
// model: firmware that flips count direction on each button press
// assumes: press is a one-cycle level sampled on ref_clk
`timescale 1ns/1ps
`default_nettype none
module fw_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic user_push_button,
  output var updown_pkg::ctrl_s ctrl_word
);
  import updown_pkg::*;
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ctrl_word <= '0;
    end else begin
      // spare bits carry junk to show the counter ignores them
      ctrl_word.spare_one <= ~ctrl_word.spare_one;
      if (user_push_button) begin
        ctrl_word.direction_select <= ~ctrl_word.direction_select;
        ctrl_word.spare_two <= ~ctrl_word.spare_two;
      end
    end
  end
endmodule : fw_model
`default_nettype wire

/* verification/tb_top.sv */
// bench: counter stepping, wrap, direction flips and reset
// assumes: fw_model drives the control word
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import updown_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic press = 1'b0;
  logic dir_exp = DIR_UP;
  logic [COUNT_W-1:0] exp = COUNT_RST;
  logic [COUNT_W-1:0] count_out;
  ctrl_s ctrl_word;
  stat_s stat_word;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #25 ref_clk = ~ref_clk;
  fw_model i_fw_model (.ref_clk(ref_clk), .rst_n(rst_n), .user_push_button(press),
    .ctrl_word(ctrl_word));
  lut_up_down_counter_3bit i_lut_up_down_counter_3bit (.ref_clk(ref_clk), .rst_n(rst_n),
    .ctrl_word(ctrl_word), .stat_word(stat_word), .count_out(count_out));
  task automatic check(input logic [COUNT_W-1:0] seen, input logic [COUNT_W-1:0] want);
    n_tests++;
    if (seen !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic tick(input logic p);
    press = p;
    @(negedge ref_clk);
    exp = (dir_exp == DIR_UP) ? exp + COUNT_STEP : exp - COUNT_STEP;
    if (p) dir_exp = ~dir_exp;
    check(count_out, exp);
    check(stat_word.count, exp);
  endtask : tick
  task automatic t_reset();
    rst_n = 1'b0;
    press = 1'b0;
    repeat (2) @(negedge ref_clk);
    check(count_out, COUNT_RST);
    rst_n = 1'b1;
    exp = COUNT_RST;
    dir_exp = DIR_UP;
  endtask : t_reset
  // up through 7 to 0, then down through 0 to 7
  task automatic t_wrap();
    repeat (9) tick(1'b0);
    tick(1'b1);
    repeat (9) tick(1'b0);
  endtask : t_wrap
  // presses on back-to-back edges
  task automatic t_flip();
    repeat (5) tick(1'b1);
    repeat (3) tick(1'b0);
  endtask : t_flip
  task automatic summarize();
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 500) begin
      n_errors++;
      summarize();
    end
  end
  initial begin
    t_reset();
    t_wrap();
    t_flip();
    t_reset();
    t_wrap();
    summarize();
  end
endmodule : tb_top
`default_nettype wire
